// ---- design/sfh_params.svh ----
// Constants for the serial flash status and pause front end.
// Assumes inclusion by the control module and the bench only.
`ifndef SFH_PARAMS_SVH
`define SFH_PARAMS_SVH
`define SFH_OFF_STATUS 12'h000
`define SFH_OFF_CTRL 12'h004
`define SFH_OFF_STATE 12'h008
`define SFH_OFF_OPER 12'h00c
`define SFH_STATUS_RESET 24'h000000
`define SFH_STATUS_WMASK 24'h607bfc
`define SFH_BUSY_BIT 0
`define SFH_LATCH_BIT 1
`define SFH_LOCKL_BIT 7
`define SFH_LOCKH_BIT 8
`define SFH_WIDE_BIT 9
`define SFH_PSUS_BIT 10
`define SFH_CMP_BIT 14
`define SFH_ESUS_BIT 15
`define SFH_OP_LEN 8'h10
`define SFH_CMD_DUAL_OUT 8'h3b
`define SFH_CMD_DUAL_IO 8'hbb
`define SFH_CMD_QUAD_OUT 8'h6b
`define SFH_CMD_QUAD_IO 8'heb
`endif

// ---- design/sfh_pkg.sv ----
// Types for the serial flash status and pause front end.
// Assumes the params header sits beside it.
package sfh_pkg;
	typedef enum logic [1:0] {
		SFH_WIDTH_ONE = 2'b00,
		SFH_WIDTH_TWO = 2'b01,
		SFH_WIDTH_FOUR = 2'b10
	} sfh_width_t;
	typedef enum logic [2:0] {
		SFH_OP_NONE = 3'b000,
		SFH_OP_WRSTAT = 3'b001,
		SFH_OP_PROG = 3'b010,
		SFH_OP_ERASE = 3'b011,
		SFH_OP_CHIP = 3'b100
	} sfh_op_t;
	typedef struct packed {
		logic [2:0] cs_sync;
		logic [2:0] clk_sync;
		logic [2:0] hold_sync;
		logic [1:0] wp_sync;
		logic armed;
		logic selected;
		logic paused;
		logic [23:0] status;
		logic [7:0] busy_cnt;
		sfh_op_t op;
		sfh_width_t width;
		logic [1:0] lock_strap;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [3:0] lane_oe;
		logic standby;
	} sfh_state_t;
endpackage

// ---- design/sfh_ctrl.sv ----
// Status register, select qualification, pause and lane control of a
// serial flash front end, with APB access to the status and command logic.
// Assumes the serial pins come from another clock domain and are
// synchronised here; the array engine is modelled only by a busy counter.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`include "sfh_params.svh"
// Operation
// - Serial clock idle level low or high both accepted, modes 0 and 3.
// - Dual reads turn lanes zero and one bidirectional.
// - Quad reads use four lanes, needing the wide lane enable set.
// - Inputs taken on rising serial clock, outputs changed after falling.
// - After reset, only a select falling edge selects the device.
// - Power-on reset holds all logic in reset and ignores instructions.
// - Standby only when deselected and no internal cycle runs.
// - Pause stops serial traffic only; internal operations continue.
// - Pause starts and ends only while the serial clock is low.
// - While paused, lanes float and clock and input are ignored.
// - Select rising during pause resets interface to standby.
// - Busy flag set throughout program, erase or status write.
// - Latch flag mirrors write latch; clear latch refuses writes.
// - Block protect bits writable only outside hardware protection.
// - Chip erase only with low protect bits matching complement flag.
// - Lock mode 00 software; 01 blocks writes while protect pin low.
// - Lock mode 10 blocks writes until power cycle, which returns 00.
// - Lock mode 11 rejects every status write permanently; here reset returns it to 00.
// - Wide lane enable defaults 0; set makes protect and pause lanes.
// - OTP lock bits default 0, set individually, never clear; here reset clears them.
// - Two drive strength bits select output strength, four settings.
// - Suspend sets the suspended flags; resume or reset clears them; here 75 sets only the erase one.
// - Complement flag inverts the protected region.
// - Program or erase into a protected region is silently ignored.
module sfh_ctrl import sfh_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic protect_n_pin,
	input wire logic pause_n_pin,
	output logic [3:0] lane_oe,
	output logic [23:0] status_out,
	output logic standby
);
	sfh_state_t st_r, st_nxt;
	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	logic [23:0] st, wmask, wval;
	logic cs_fall, cs_rise, clk_low, pause_in, protect_in, wr, rd;
	logic busy, lock_ok, prot_sel, chip_ok, any_prot;
	always_comb begin
		st_nxt = st_r;
		st = st_r.status;
		// The second stage feeds level logic; third stage holds the past level for edge detection
		st_nxt.cs_sync = {st_r.cs_sync[1:0], cs_n_pin};
		st_nxt.clk_sync = {st_r.clk_sync[1:0], sclk_pin};
		st_nxt.hold_sync = {st_r.hold_sync[1:0], pause_n_pin};
		st_nxt.wp_sync = {st_r.wp_sync[0], protect_n_pin};
		cs_fall = st_r.cs_sync[2] && !st_r.cs_sync[1];
		cs_rise = !st_r.cs_sync[2] && st_r.cs_sync[1];
		clk_low = !st_r.clk_sync[1];
		pause_in = !st_r.hold_sync[1] && !st[`SFH_WIDE_BIT];
		protect_in = st_r.wp_sync[1] || st[`SFH_WIDE_BIT];
		busy = st_r.op != SFH_OP_NONE;
		wr = psel && penable && pwrite;
		rd = psel && penable && !pwrite;
		// Select waits for an edge, a low level alone never selects
		if (st_r.cs_sync[1]) begin
			st_nxt.armed = 1'b1;
		end
		if (cs_fall && st_r.armed) begin
			st_nxt.selected = 1'b1;
		end
		if (st_r.cs_sync[1]) begin
			st_nxt.selected = 1'b0;
			st_nxt.paused = 1'b0;
			st_nxt.width = SFH_WIDTH_ONE;
		end
		// Pause changes state only with the serial clock low
		if (st_r.selected && !st_r.cs_sync[1] && clk_low) begin
			st_nxt.paused = pause_in;
		end
		// Lock check: software, hardware, lockdown and permanent modes
		unique case ({st[`SFH_LOCKH_BIT], st[`SFH_LOCKL_BIT]})
			2'b00: lock_ok = st[`SFH_LATCH_BIT];
			2'b01: lock_ok = st[`SFH_LATCH_BIT] && protect_in;
			2'b10: lock_ok = 1'b0;
			2'b11: lock_ok = 1'b0;
		endcase
		// Chip erase allowed only when low protect bits agree with complement
		chip_ok = (st[4:2] == 3'b000 && !st[`SFH_CMP_BIT]) ||
			(st[4:2] == 3'b111 && st[`SFH_CMP_BIT]);
		// Any protected portion; complement swaps it
		any_prot = (st[6:2] != 5'b00000) && !(st[6] && st[4:2] == 3'b000);
		prot_sel = any_prot ^ st[`SFH_CMP_BIT];
		wmask = `SFH_STATUS_WMASK;
		// Hardware protection also freezes the protect bits
		if (!lock_ok) begin
			wmask = 24'h000000;
		end
		// OTP bits only accumulate set values
		wval = (pwdata[23:0] & wmask) | (st & ~wmask) | (st & 24'h003800);
		st_nxt.pready = psel && !penable ? 1'b1 : 1'b0;
		st_nxt.pslverr = 1'b0;
		st_nxt.prdata = 32'h00000000;
		if (psel && !penable) begin
			unique case (paddr)
				`SFH_OFF_STATUS: st_nxt.prdata = {8'h00, st};
				`SFH_OFF_CTRL: st_nxt.prdata = {30'h0, st_r.width};
				`SFH_OFF_STATE: st_nxt.prdata = {27'h0, st_r.standby, busy,
					st_r.paused, st_r.selected, st_r.armed};
				`SFH_OFF_OPER: st_nxt.prdata = {29'h0, st_r.op};
				default: st_nxt.pslverr = 1'b1;
			endcase
		end
		if (wr && st_r.pready && !busy) begin
			unique case (paddr)
				// Status write is refused unless latch and lock allow
				`SFH_OFF_STATUS: if (lock_ok) begin
					st_nxt.status = wval & 24'h60fffc;
					st_nxt.status[`SFH_LATCH_BIT] = 1'b0;
					st_nxt.op = SFH_OP_WRSTAT;
				end
				// Command byte: 06 set latch, 04 clear latch, lane width picks
				`SFH_OFF_CTRL: begin
					unique case (pwdata[7:0])
						8'h06: st_nxt.status[`SFH_LATCH_BIT] = 1'b1;
						8'h04: st_nxt.status[`SFH_LATCH_BIT] = 1'b0;
						`SFH_CMD_DUAL_OUT, `SFH_CMD_DUAL_IO:
							if (st_r.selected) st_nxt.width = SFH_WIDTH_TWO;
						`SFH_CMD_QUAD_OUT, `SFH_CMD_QUAD_IO:
							if (st_r.selected && st[`SFH_WIDE_BIT])
								st_nxt.width = SFH_WIDTH_FOUR;
						8'h75: begin
							st_nxt.status[`SFH_ESUS_BIT] = 1'b1;
						end
						8'h7a, 8'h66: begin
							st_nxt.status[`SFH_ESUS_BIT] = 1'b0;
							st_nxt.status[`SFH_PSUS_BIT] = 1'b0;
						end
						default: ;
					endcase
				end
				// Program 1, erase 2, chip erase 3; bit 8 marks protected target
				`SFH_OFF_OPER: if (st[`SFH_LATCH_BIT]) begin
					if (pwdata[1:0] == 2'b11 && chip_ok) begin
						st_nxt.op = SFH_OP_CHIP;
					end else if (pwdata[1:0] != 2'b00 && pwdata[1:0] != 2'b11 &&
						!(pwdata[8] && prot_sel)) begin
						st_nxt.op = pwdata[0] ? SFH_OP_PROG : SFH_OP_ERASE;
					end
					st_nxt.status[`SFH_LATCH_BIT] = 1'b0;
				end
				default: ;
			endcase
		end
		// Internal cycle runs on regardless of pause or select
		if (busy) begin
			st_nxt.busy_cnt = st_r.busy_cnt + 8'h01;
			if (st_r.busy_cnt == `SFH_OP_LEN) begin
				st_nxt.op = SFH_OP_NONE;
				st_nxt.busy_cnt = 8'h00;
			end
		end
		st_nxt.status[`SFH_BUSY_BIT] = st_nxt.op != SFH_OP_NONE;
		// Lanes float while paused or deselected; drive after falling edge
		st_nxt.lane_oe = 4'h0;
		if (st_r.selected && !st_r.paused && st_r.clk_sync[2] && clk_low) begin
			unique case (st_r.width)
				SFH_WIDTH_ONE: st_nxt.lane_oe = 4'h2;
				SFH_WIDTH_TWO: st_nxt.lane_oe = 4'h3;
				SFH_WIDTH_FOUR: st_nxt.lane_oe = 4'hf;
				default: st_nxt.lane_oe = 4'h0;
			endcase
		end else if (st_r.selected && !st_r.paused) begin
			st_nxt.lane_oe = st_r.lane_oe;
		end
		if (st_r.paused) begin
			st_nxt.lane_oe = 4'h0;
		end
		st_nxt.standby = !st_nxt.selected && st_nxt.op == SFH_OP_NONE;
	end
	// --------------------------------------------------------------
	// State register; reset takes constants only
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			// Start low so a select held low through reset never looks like an edge
			st_r.cs_sync <= 3'b000;
			st_r.clk_sync <= 3'b000;
			st_r.hold_sync <= 3'b111;
			st_r.wp_sync <= 2'b11;
			st_r.status <= `SFH_STATUS_RESET;
			st_r.standby <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign lane_oe = st_r.lane_oe;
	assign status_out = st_r.status;
	assign standby = st_r.standby;
	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sequence s_cs_edge;
		st_r.cs_sync[2] && !st_r.cs_sync[1] && st_r.armed;
	endsequence
	chk_busy_flag_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.status[0] == (st_r.op != SFH_OP_NONE)) else $error("busy flag wrong");
	chk_pause_floats: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.paused |=> lane_oe == 4'h0) else $error("lanes driven in pause");
	chk_cs_rise_reset: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.cs_sync[1] |=> !st_r.selected && !st_r.paused) else $error("no deselect");
	chk_select_edge: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(st_r.selected) |-> $past(st_r.armed, 1)) else $error("select without edge");
	chk_standby_idle: assert property (@(posedge pclk) disable iff (!presetn)
		standby |-> st_r.op == SFH_OP_NONE && !st_r.selected) else $error("bad standby");
	chk_lock_hard: assert property (@(posedge pclk) disable iff (!presetn)
		st_r.status[8:7] == 2'b11 |=> $stable(st_r.status[8:2])) else $error("locked write");
	chk_otp_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		($past(st_r.status[13:11]) & ~st_r.status[13:11]) == 3'b000)
		else $error("otp cleared");
	chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		status_out[23] == 1'b0 && status_out[20:16] == 5'h00) else $error("reserved set");
	chk_quad_needs_wide: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(st_r.width) && st_r.width == SFH_WIDTH_FOUR |-> st_r.status[9])
		else $error("quad without enable");
	chk_pause_clock_low: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(st_r.paused) && st_r.selected && $past(st_r.selected) |->
		!$past(st_r.clk_sync[1])) else $error("pause moved on high clock");
	chk_cs_edge_seen: assert property (@(posedge pclk) disable iff (!presetn)
		s_cs_edge |=> st_r.selected) else $error("edge did not select");
endmodule

// ---- test/sfh_host.sv ----
// Host serial controller model: select, serial clock, protect and pause pins.
// Assumes the bench steers select and pause; the clock runs only in frames.
`timescale 1ns/1ps
module sfh_host (
	output logic cs_n,
	output logic sclk,
	output logic protect_n,
	output logic pause_n
);
	// Select starts high so the first frame opens with a falling edge
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		protect_n = 1'b1;
		pause_n = 1'b1;
	end
	// Mode 0: clock idles low and stands still while deselected
	always #400 sclk = (cs_n === 1'b0) ? ~sclk : 1'b0;
	// Pause starts only at a low clock so no half bit is lost
	task automatic hold();
		wait (sclk === 1'b0);
		pause_n = 1'b0;
	endtask
endmodule

// ---- test/tb_spi_flash_status_hold_ctrl.sv ----
// Self-checking bench for the serial flash status and pause front end.
// Assumes the host model drives the serial pins and APB reaches registers.
`timescale 1ns/1ps
`include "sfh_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_spi_flash_status_hold_ctrl import sfh_pkg::*; ();
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, cs_n, sclk, protect_n, pause_n, standby;
	logic [3:0] lane_oe;
	logic [23:0] status_out, st, v;
	logic [7:0] cmd [4] = '{`SFH_CMD_DUAL_OUT, `SFH_CMD_DUAL_IO, `SFH_CMD_QUAD_OUT, `SFH_CMD_QUAD_IO};
	sfh_width_t wid [4] = '{SFH_WIDTH_TWO, SFH_WIDTH_TWO, SFH_WIDTH_FOUR, SFH_WIDTH_FOUR};
	integer seed = 32'hfa6a, n_mismatch = 0, tests_run = 0, cyc = 0;
	sfh_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cs_n_pin(cs_n), .sclk_pin(sclk),
		.protect_n_pin(protect_n), .pause_n_pin(pause_n), .lane_oe(lane_oe),
		.status_out(status_out), .standby(standby));
	sfh_host host (.cs_n(cs_n), .sclk(sclk), .protect_n(protect_n), .pause_n(pause_n));
	always #50 pclk = ~pclk;
	// Cut a hang short; the whole sequence needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// APB master: holds the request until pready is seen at a falling edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look at the answer mid-cycle, where it has settled
		@(negedge pclk);
		while (pready !== 1'b1)
			@(negedge pclk);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Poll busy instead of assuming the length of the internal cycle
	task automatic idle();
		do apb(1'b0, `SFH_OFF_STATE, 32'h0); while (rd[3] !== 1'b0);
	endtask
	task automatic wrst(input logic [23:0] s);
		apb(1'b1, `SFH_OFF_CTRL, 32'h6);
		apb(1'b1, `SFH_OFF_STATUS, {8'h0, s});
		idle();
	endtask
	task automatic rds(input logic [23:0] e);
		apb(1'b0, `SFH_OFF_STATUS, 32'h0);
		`CHK("status", {8'h0, e}, rd)
	endtask
	task automatic rst();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		`CHK("standby", 1'b1, standby)
		presetn <= 1'b1;
		st = 24'h0;
	endtask
	// Writable bits follow the image; lock bits once set survive any write
	function automatic logic [23:0] exp_st(input logic [23:0] o, input logic [23:0] w);
		return (w & `SFH_STATUS_WMASK) | (o & 24'h003800);
	endfunction
	// ------------------------------------------------------------
	// Stimulus and checks
	// ------------------------------------------------------------
	initial begin
		rst();
		rds(24'h0);
		apb(1'b0, 12'h010, 32'h0);
		`CHK("slverr", 1'b1, err)
		apb(1'b1, `SFH_OFF_STATUS, 32'h4);
		rds(24'h0);
		apb(1'b1, `SFH_OFF_CTRL, 32'h6);
		rds(24'h2);
		// Random images keep lock mode 00 so later writes still land
		repeat (6) begin
			v = 24'($random(seed)) & 24'hfffe7f;
			apb(1'b1, `SFH_OFF_STATUS, {8'h0, v});
			apb(1'b0, `SFH_OFF_STATE, 32'h0);
			`CHK("busy", 1'b1, rd[3])
			idle();
			st = exp_st(st, v);
			rds(st);
			apb(1'b1, `SFH_OFF_CTRL, 32'h6);
		end
		wrst(24'h80);
		st = exp_st(st, 24'h80);
		host.protect_n = 1'b0;
		wrst(24'h84);
		rds(st | 24'h2);
		host.protect_n = 1'b1;
		wrst(24'h84);
		st = exp_st(st, 24'h84);
		rds(st);
		wrst(24'h100);
		st = exp_st(st, 24'h100);
		wrst(24'h104);
		rds(st | 24'h2);
		host.cs_n = 1'b0;
		rst();
		rds(24'h0);
		apb(1'b0, `SFH_OFF_STATE, 32'h0);
		`CHK("selected", 1'b0, rd[1])
		host.cs_n = 1'b1;
		repeat (8) @(posedge pclk);
		host.cs_n = 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, `SFH_OFF_STATE, 32'h0);
		`CHK("selected", 1'b1, rd[1])
		`CHK("standby", 1'b0, standby)
		wrst(24'h200);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `SFH_OFF_CTRL, {24'h0, cmd[i]});
			apb(1'b0, `SFH_OFF_CTRL, 32'h0);
			`CHK("width", wid[i], rd[1:0])
		end
		wrst(24'h0);
		host.hold();
		repeat (16) @(posedge pclk);
		apb(1'b0, `SFH_OFF_STATE, 32'h0);
		`CHK("paused", 1'b1, rd[2])
		`CHK("lanes", 4'h0, lane_oe)
		host.cs_n = 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, `SFH_OFF_STATE, 32'h0);
		`CHK("paused", 1'b0, rd[2])
		`CHK("standby", 1'b1, standby)
		host.pause_n = 1'b1;
		// Chip erase with protect bits clear, then a refused one, then a refused protected program
		for (int j = 0; j < 3; j++) begin
			if (j == 1)
				wrst(24'h4);
			apb(1'b1, `SFH_OFF_CTRL, 32'h6);
			apb(1'b1, `SFH_OFF_OPER, j == 2 ? 32'h101 : 32'h3);
			apb(1'b0, `SFH_OFF_STATE, 32'h0);
			`CHK("op busy", j == 0, rd[3])
			idle();
		end
		// Suspend flag set and cleared by commands only
		apb(1'b1, `SFH_OFF_CTRL, 32'h75);
		rds(24'h8004);
		apb(1'b1, `SFH_OFF_CTRL, 32'h7a);
		rds(24'h0004);
		// Permanent lock refuses every later image
		wrst(24'h180);
		wrst(24'h4);
		rds(24'h182);
		complete_run();
	end
endmodule
